// [hdl/wps_pkg.sv]
// Purpose: constants and types of the wake-up preamble scheduler
// Assumes: single clock clk at 20 MHz, asynchronous active-low reset
// Notes:   all timing counts derive from the clock rate below
//
// Operation
// - idle threshold set or read by code 0x03
// - idle threshold 0..0xFFFF, units of 100 ms
// - threshold resets to 0xFFFF, which disables preamble
// - threshold read answers with two bytes
// - idle means neither transmitting nor receiving
// - threshold reached: long preamble before next send
// - sleeping peers get a wake-up preamble
// - receiver enters cyclic sleep after sleep timeout
// - cyclic sleeper wakes once per sleep interval
// - detected preamble keeps receiver awake for data
// - preamble length 0..0xFF, units of 100 ms
// - stay awake only after about 35 ms preamble
package wps_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned TICK_MS        = 100;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DETECT_MS      = 35;
  localparam int unsigned DETECT_CYCLES  = CLK_HZ / 1000 * DETECT_MS;
  localparam int unsigned LISTEN_MS      = 50;
  localparam int unsigned LISTEN_CYCLES  = CLK_HZ / 1000 * LISTEN_MS;
  localparam int unsigned DIV_W          = 32;
  localparam int unsigned DET_W          = 24;

  // ***********************************************************
  // command codes and answers
  // ***********************************************************
  localparam logic [7:0]  CMD_SLEEP_MODE    = 8'h01;
  localparam logic [7:0]  CMD_SLEEP_TIMEOUT = 8'h02;
  localparam logic [7:0]  CMD_IDLE_THR      = 8'h03;
  localparam logic [7:0]  CMD_PRE_LEN       = 8'h0C;
  localparam logic [1:0]  BYTES_NONE        = 2'h0;
  localparam logic [1:0]  BYTES_ONE         = 2'h1;
  localparam logic [1:0]  BYTES_TWO         = 2'h2;

  // ***********************************************************
  // reset values and limits
  // ***********************************************************
  localparam logic [15:0] IDLE_THR_RST      = 16'hFFFF;
  localparam logic [15:0] IDLE_THR_OFF      = 16'hFFFF;
  localparam logic [7:0]  PRE_LEN_RST       = 8'h01;
  localparam logic [15:0] SLEEP_TO_RST      = 16'h0014;
  localparam logic [7:0]  SLEEP_MODE_RST    = 8'h00;
  localparam logic [7:0]  SLEEP_MODE_MAX    = 8'h07;

  // ***********************************************************
  // states
  // ***********************************************************
  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_WAIT} wps_tx_t;
  typedef enum logic [1:0] {RX_AWAKE, RX_SLEEP, RX_LISTEN} wps_rx_t;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } wps_div_state_t;

  typedef struct packed {
    logic [15:0] cnt;
  } wps_cnt_state_t;

  typedef struct packed {
    logic [15:0]      idleThr;
    logic [7:0]       preLen;
    logic [15:0]      sleepTo;
    logic [7:0]       sleepMode;
    wps_tx_t          txState;
    logic [7:0]       preCnt;
    logic             preambleOn;
    logic             txGo;
    logic             longPending;
    wps_rx_t          rxState;
    logic [7:0]       sleepCnt;
    logic [DET_W-1:0] detCnt;
    logic [DET_W-1:0] lisCnt;
    logic             sleeping;
    logic             radioOn;
    logic             rspValid;
    logic [15:0]      rspData;
    logic [1:0]       rspBytes;
    logic             cmdError;
  } wps_state_t;

endpackage

// [hdl/wps_tick_div.sv]
// Purpose: divider giving a one-cycle tick every Cycles clocks
// Assumes: Cycles is at least 1
// Notes:   restart realigns the tick phase to the current cycle
`timescale 1ns/1ps
`default_nettype none
module wps_tick_div #(
  parameter int unsigned Cycles = wps_pkg::TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic restart,
  output logic      tick
);
  import wps_pkg::*;

  localparam logic [DIV_W-1:0] LAST = DIV_W'(Cycles - 1);

  wps_div_state_t q;
  wps_div_state_t d;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (restart) begin
      d.cnt = '0;
    end else if (q.cnt >= LAST) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule
`default_nettype wire

// [hdl/wps_sat_cnt.sv]
// Purpose: 16-bit saturating tick counter with synchronous clear
// Assumes: clr has priority over inc
// Notes:   holding at 0xFFFF keeps a long idle from wrapping to zero
`timescale 1ns/1ps
`default_nettype none
module wps_sat_cnt (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clr,
  input  wire logic        inc,
  output logic [15:0]      count
);
  import wps_pkg::*;

  wps_cnt_state_t q;
  wps_cnt_state_t d;

  always_comb begin
    d = q;
    if (clr) begin
      d.cnt = '0;
    end else if (inc && (q.cnt != 16'hFFFF)) begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count = q.cnt;
endmodule
`default_nettype wire

// [hdl/wps_scheduler.sv]
// Purpose: idle timer, wake-up preamble and cyclic sleep scheduling
// Assumes: radio status inputs are synchronous to clk
// Notes:   host holds txRequest until txGo, then drops it
`timescale 1ns/1ps
`default_nettype none
module wps_scheduler #(
  parameter int unsigned TickCycles   = wps_pkg::TICK_CYCLES,
  parameter int unsigned DetectCycles = wps_pkg::DETECT_CYCLES,
  parameter int unsigned ListenCycles = wps_pkg::LISTEN_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [15:0] cmdData,
  input  wire logic        txRequest,
  input  wire logic        txActive,
  input  wire logic        rxActive,
  input  wire logic        preambleDetect,
  output logic             rspValid,
  output logic [15:0]      rspData,
  output logic [1:0]       rspBytes,
  output logic             cmdError,
  output logic             preambleOn,
  output logic             txGo,
  output logic             longPending,
  output logic             sleeping,
  output logic             radioOn
);
  import wps_pkg::*;

  // ***********************************************************
  // constants at counter width
  // ***********************************************************
  localparam logic [DET_W-1:0] DET_LAST = DET_W'(DetectCycles - 1);
  localparam logic [DET_W-1:0] LIS_LAST = DET_W'(ListenCycles - 1);

  wps_state_t  q;
  wps_state_t  d;
  logic        tick;
  logic        divRestart;
  logic [15:0] idleCnt;
  logic        idleNow;
  logic        idleClr;
  logic        longNeed;

  // ***********************************************************
  // shared 100 ms tick and idle counter
  // ***********************************************************
  wps_tick_div #(
    .Cycles (TickCycles)
  ) u_div (
    .clk     (clk),
    .arst_n  (arst_n),
    .restart (divRestart),
    .tick    (tick)
  );

  // a preamble on air counts as transmit activity
  assign idleNow = !txActive && !rxActive && !q.preambleOn;
  // a wake-up from listening is treated as activity as well
  assign idleClr = !idleNow
                   || (q.rxState == RX_LISTEN && d.rxState == RX_AWAKE);

  wps_sat_cnt u_idle (
    .clk    (clk),
    .arst_n (arst_n),
    .clr    (idleClr),
    .inc    (tick && idleNow),
    .count  (idleCnt)
  );

  // threshold 0xFFFF never arms the long preamble
  assign longNeed = (q.idleThr != IDLE_THR_OFF)
                    && (idleCnt >= q.idleThr);

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    d            = q;
    divRestart   = 1'b0;
    d.txGo       = 1'b0;
    d.rspValid   = 1'b0;
    d.cmdError   = 1'b0;
    d.longPending = longNeed;

    // host commands; a write answers with zero bytes
    if (cmdValid) begin
      d.rspValid = 1'b1;
      d.rspBytes = BYTES_NONE;
      case (cmdCode)
        CMD_IDLE_THR: begin
          if (cmdWrite) begin
            d.idleThr = cmdData;
          end else begin
            d.rspData  = q.idleThr;
            d.rspBytes = BYTES_TWO;
          end
        end
        CMD_PRE_LEN: begin
          if (cmdWrite) begin
            if (cmdData[15:8] == 8'h00) begin
              d.preLen = cmdData[7:0];
            end else begin
              d.cmdError = 1'b1;
            end
          end else begin
            d.rspData  = {8'h00, q.preLen};
            d.rspBytes = BYTES_ONE;
          end
        end
        CMD_SLEEP_TIMEOUT: begin
          if (cmdWrite) begin
            d.sleepTo = cmdData;
          end else begin
            d.rspData  = q.sleepTo;
            d.rspBytes = BYTES_TWO;
          end
        end
        CMD_SLEEP_MODE: begin
          if (cmdWrite) begin
            if (cmdData <= {8'h00, SLEEP_MODE_MAX}) begin
              d.sleepMode = cmdData[7:0];
            end else begin
              d.cmdError = 1'b1;
            end
          end else begin
            d.rspData  = {8'h00, q.sleepMode};
            d.rspBytes = BYTES_ONE;
          end
        end
        default: begin
          d.cmdError = 1'b1;
        end
      endcase
    end

    // transmit side
    case (q.txState)
      TX_IDLE: begin
        if (txRequest && q.rxState == RX_AWAKE) begin
          if (longNeed && q.preLen != 8'h00) begin
            d.txState    = TX_PRE;
            d.preCnt     = 8'h00;
            d.preambleOn = 1'b1;
            divRestart   = 1'b1;
          end else begin
            d.txGo    = 1'b1;
            d.txState = TX_WAIT;
          end
        end
      end
      TX_PRE: begin
        // length counts whole ticks from the realigned divider
        if (tick) begin
          if (q.preCnt + 8'h01 >= q.preLen) begin
            d.preambleOn = 1'b0;
            d.txGo       = 1'b1;
            d.txState    = TX_WAIT;
          end else begin
            d.preCnt = q.preCnt + 8'h01;
          end
        end
      end
      TX_WAIT: begin
        if (!txRequest) begin
          d.txState = TX_IDLE;
        end
      end
      default: begin
        d.txState    = TX_IDLE;
        d.preambleOn = 1'b0;
      end
    endcase

    // receive side
    case (q.rxState)
      RX_AWAKE: begin
        if (q.sleepMode != 8'h00 && idleNow && idleCnt >= q.sleepTo
            && q.txState == TX_IDLE && !txRequest) begin
          d.rxState  = RX_SLEEP;
          d.sleepCnt = 8'h00;
          divRestart = 1'b1;
        end
      end
      RX_SLEEP: begin
        if (txRequest) begin
          d.rxState = RX_AWAKE;
        end else if (tick) begin
          // interval is sleepMode ticks of 100 ms
          if (q.sleepCnt + 8'h01 >= q.sleepMode) begin
            d.rxState = RX_LISTEN;
            d.detCnt  = '0;
            d.lisCnt  = '0;
          end else begin
            d.sleepCnt = q.sleepCnt + 8'h01;
          end
        end
      end
      RX_LISTEN: begin
        if (preambleDetect) begin
          d.detCnt = q.detCnt + 1'b1;
        end else begin
          d.detCnt = '0;
        end
        d.lisCnt = q.lisCnt + 1'b1;
        if (txRequest) begin
          d.rxState = RX_AWAKE;
        end else if (preambleDetect && q.detCnt >= DET_LAST) begin
          d.rxState = RX_AWAKE;
        end else if (q.lisCnt >= LIS_LAST) begin
          // short or missing preamble: back to sleep for one interval
          d.rxState  = RX_SLEEP;
          d.sleepCnt = 8'h00;
          divRestart = 1'b1;
        end
      end
      default: begin
        d.rxState = RX_AWAKE;
      end
    endcase

    d.sleeping = (d.rxState == RX_SLEEP);
    d.radioOn  = (d.rxState != RX_SLEEP);
  end

  // ***********************************************************
  // state register
  // ***********************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q             <= '0;
      q.idleThr     <= IDLE_THR_RST;
      q.preLen      <= PRE_LEN_RST;
      q.sleepTo     <= SLEEP_TO_RST;
      q.sleepMode   <= SLEEP_MODE_RST;
      q.txState     <= TX_IDLE;
      q.rxState     <= RX_AWAKE;
      q.radioOn     <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rspValid    = q.rspValid;
  assign rspData     = q.rspData;
  assign rspBytes    = q.rspBytes;
  assign cmdError    = q.cmdError;
  assign preambleOn  = q.preambleOn;
  assign txGo        = q.txGo;
  assign longPending = q.longPending;
  assign sleeping    = q.sleeping;
  assign radioOn     = q.radioOn;
endmodule
`default_nettype wire

// [tb/wps_monitor.sv]
// Purpose: port checker for wps_scheduler
// Assumes: bound to every scheduler instance
// Notes:   sleep bound allows the longest interval plus the realign cycle
`timescale 1ns/1ps
`default_nettype none
module wps_monitor #(
  parameter int unsigned TickCycles = wps_pkg::TICK_CYCLES
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       cmdValid,
  input wire logic       cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic       txRequest,
  input wire logic       rspValid,
  input wire logic [1:0] rspBytes,
  input wire logic       cmdError,
  input wire logic       preambleOn,
  input wire logic       txGo,
  input wire logic       sleeping,
  input wire logic       radioOn
);
  // ********
  // helpers
  // ********
  // longest legal sleep: seven ticks plus the realign cycle
  localparam int unsigned SLP_MAX = wps_pkg::SLEEP_MODE_MAX * TickCycles + 2;
  logic [31:0] slpCnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slpCnt <= 32'h0;
    end else if (sleeping) begin
      slpCnt <= slpCnt + 32'h1;
    end else begin
      slpCnt <= 32'h0;
    end
  end
  // ********
  // checks
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_rsp; cmdValid |=> rspValid; endproperty
  a_rsp: assert property (p_rsp) else $error("no answer");
  property p_rd;
    cmdValid && !cmdWrite && cmdCode == 8'h03 |=> rspBytes == 2'h2;
  endproperty
  a_rd: assert property (p_rd) else $error("bad byte count");
  property p_err; cmdError |-> rspValid; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_go; $fell(preambleOn) |-> txGo; endproperty
  a_go: assert property (p_go) else $error("no send");
  property p_one; txGo |=> !txGo; endproperty
  a_one: assert property (p_one) else $error("long send");
  // shortest preamble is one tick, at least eight cycles
  property p_len; $rose(preambleOn) |-> preambleOn [*8]; endproperty
  a_len: assert property (p_len) else $error("short preamble");
  property p_slp; sleeping |-> !radioOn; endproperty
  a_slp: assert property (p_slp) else $error("radio on");
  // a sleeper that never listens again would run past the bound
  property p_chk; sleeping |-> slpCnt < SLP_MAX; endproperty
  a_chk: assert property (p_chk) else $error("no listen");
  property p_wake; sleeping && txRequest |=> radioOn; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  c_pre: cover property ($rose(preambleOn));
  c_slp: cover property ($rose(sleeping));
  c_err: cover property (cmdError);
endmodule
bind wps_scheduler wps_monitor #(.TickCycles(TickCycles)) i_wps_monitor (
  .clk(clk),
  .arst_n(arst_n),
  .cmdValid(cmdValid),
  .cmdWrite(cmdWrite),
  .cmdCode(cmdCode),
  .txRequest(txRequest),
  .rspValid(rspValid),
  .rspBytes(rspBytes),
  .cmdError(cmdError),
  .preambleOn(preambleOn),
  .txGo(txGo),
  .sleeping(sleeping),
  .radioOn(radioOn)
);
`default_nettype wire

// [tb/wps_peer_model.sv]
// Purpose: radio and peer activity around the scheduler
// Assumes: levels from the bench change at the falling edge
// Notes:   a send keeps the radio busy for ten cycles
`timescale 1ns/1ps
`default_nettype none
module wps_peer_model (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic txGo,
  input  wire logic rxHold,
  input  wire logic preHold,
  output logic      txActive,
  output logic      rxActive,
  output logic      preambleDetect
);
  // ********
  // activity
  // ********
  logic [3:0] txCnt;
  assign txActive = txCnt != 4'h0;
  assign rxActive = rxHold;
  assign preambleDetect = preHold;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txCnt <= 4'h0;
    end else if (txGo) begin
      txCnt <= 4'hA;
    end else if (txCnt != 4'h0) begin
      txCnt <= txCnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: command and traffic sequences for wps_scheduler
// Assumes: tick shortened to 20 cycles
// Notes:   inputs move at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wps_pkg::*;
  // ********
  // setup
  // ********
  localparam int unsigned TC = 20;
  localparam logic [7:0] CODES [4] = '{8'h03, 8'h0C, 8'h02, 8'h01};
  localparam logic [15:0] RSTV [4] = '{16'hFFFF, 16'h0001, 16'h0014, 16'h0000};
  logic        clk = 1'h0;
  logic        arst_n = 1'h0;
  logic        cmdValid = 1'h0;
  logic        cmdWrite = 1'h0;
  logic [7:0]  cmdCode = 8'h00;
  logic [15:0] cmdData = 16'h0000;
  logic        txRequest = 1'h0;
  logic        rxHold = 1'h0;
  logic        preHold = 1'h0;
  logic        txActive;
  logic        rxActive;
  logic        preambleDetect;
  logic        rspValid;
  logic [15:0] rspData;
  logic [1:0]  rspBytes;
  logic        cmdError;
  logic        preambleOn;
  logic        txGo;
  logic        longPending;
  logic        sleeping;
  logic        radioOn;
  logic [15:0] rd;
  logic [1:0]  rb;
  logic        re;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n;
  int          i;
  int          p;
  wps_scheduler #(.TickCycles(TC), .DetectCycles(5), .ListenCycles(10))
  i_wps_scheduler (.clk(clk), .arst_n(arst_n), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData),
    .txRequest(txRequest), .txActive(txActive), .rxActive(rxActive),
    .preambleDetect(preambleDetect), .rspValid(rspValid),
    .rspData(rspData), .rspBytes(rspBytes), .cmdError(cmdError),
    .preambleOn(preambleOn), .txGo(txGo), .longPending(longPending),
    .sleeping(sleeping), .radioOn(radioOn));
  wps_peer_model i_wps_peer_model (.clk(clk), .arst_n(arst_n),
    .txGo(txGo), .rxHold(rxHold), .preHold(preHold),
    .txActive(txActive), .rxActive(rxActive),
    .preambleDetect(preambleDetect));
  initial begin
    forever #25 clk = ~clk;
  end
  // ********
  // tasks
  // ********
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmdValid = 1'h1;
    cmdWrite = w;
    cmdCode = c;
    cmdData = d;
    @(negedge clk);
    cmdValid = 1'h0;
    chk1(rspValid, 1'h1);
    rd = rspData;
    rb = rspBytes;
    re = cmdError;
  endtask
  // a request taken while asleep first wakes the receiver
  task automatic send();
    p = 0;
    @(negedge clk);
    txRequest = 1'h1;
    for (n = 0; n < 200 && txGo !== 1'h1; n++) begin
      @(negedge clk);
      if (preambleOn === 1'h1) p++;
    end
    txRequest = 1'h0;
  endtask
  task automatic wait_for(input logic want, input int which);
    for (i = 0; i < 80; i++) begin
      if ((which == 0 ? sleeping : radioOn) === want) break;
      @(negedge clk);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      err_count++;
      print_verdict();
    end
  end
  // ********
  // sequence
  // ********
  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1'h1;
    for (int k = 0; k < 4; k++) begin
      cmd(1'h0, CODES[k], 16'h0000);
      chk(rd, RSTV[k]);
    end
    cmd(1'h0, 8'h03, 16'h0000);
    chk({14'h0, rb}, 16'h0002);
    cmd(1'h0, 8'h0C, 16'h0000);
    chk({14'h0, rb}, 16'h0001);
    send();
    chk1(txGo, 1'h1);
    chk(p[15:0], 16'h0000);
    chk(n[15:0], 16'h0001);
    cmd(1'h1, 8'h03, 16'h1234);
    chk1(re, 1'h0);
    chk({14'h0, rb}, 16'h0000);
    cmd(1'h0, 8'h03, 16'h0000);
    chk(rd, 16'h1234);
    cmd(1'h1, 8'h0C, 16'h0100);
    chk1(re, 1'h1);
    cmd(1'h0, 8'h0C, 16'h0000);
    chk(rd, 16'h0001);
    cmd(1'h0, 8'h55, 16'h0000);
    chk1(re, 1'h1);
    cmd(1'h1, 8'h01, 16'h0008);
    chk1(re, 1'h1);
    cmd(1'h1, 8'h03, 16'h0000);
    cmd(1'h1, 8'h0C, 16'h0002);
    send();
    chk1(txGo, 1'h1);
    chk1(p >= 2 * TC && p <= 2 * TC + 1, 1'h1);
    cmd(1'h1, 8'h03, 16'h0002);
    repeat (5) begin
      rxHold = 1'h1;
      @(negedge clk);
      rxHold = 1'h0;
      repeat (15) @(negedge clk);
      chk1(longPending, 1'h0);
    end
    repeat (70) @(negedge clk);
    chk1(longPending, 1'h1);
    cmd(1'h1, 8'h03, 16'hFFFF);
    cmd(1'h1, 8'h02, 16'h0000);
    cmd(1'h1, 8'h01, 16'h0001);
    wait_for(1'h1, 0);
    chk1(radioOn, 1'h0);
    wait_for(1'h1, 1);
    chk1(sleeping, 1'h0);
    preHold = 1'h1;
    repeat (3) @(negedge clk);
    preHold = 1'h0;
    repeat (12) @(negedge clk);
    chk1(sleeping, 1'h1);
    wait_for(1'h1, 1);
    preHold = 1'h1;
    rxHold = 1'h1;
    repeat (8) @(negedge clk);
    preHold = 1'h0;
    repeat (12) @(negedge clk);
    chk1(radioOn, 1'h1);
    rxHold = 1'h0;
    wait_for(1'h1, 0);
    // one cycle to wake the receiver, then the send starts
    send();
    chk1(txGo, 1'h1);
    chk(n[15:0], 16'h0002);
    print_verdict();
  end
endmodule
`default_nettype wire
